/* ecs_defines.svh */
// constants for the capacitance/ESR snapshot bank
`ifndef ECS_DEFINES_SVH
`define ECS_DEFINES_SVH

// command codes of the snapshot words
`define ECS_CODE_CAP_CELL1 8'h34
`define ECS_CODE_CAP_CELL2 8'h35
`define ECS_CODE_CAP_CELL3 8'h36
`define ECS_CODE_CAP_CELL4 8'h37
`define ECS_CODE_BASE_CELL1 8'h38
`define ECS_CODE_BASE_CELL2 8'h39
`define ECS_CODE_BASE_CELL3 8'h3a
`define ECS_CODE_BASE_CELL4 8'h3b
`define ECS_CODE_ON1_CELL1 8'h3c
`define ECS_CODE_ON1_CELL2 8'h3d
`define ECS_CODE_ON1_CELL3 8'h3e
`define ECS_CODE_ON1_CELL4 8'h3f
`define ECS_CODE_ON1_CURRENT 8'h40
`define ECS_CODE_ON2_CELL1 8'h41
`define ECS_CODE_ON2_CELL2 8'h42
`define ECS_CODE_ON2_CELL3 8'h43
`define ECS_CODE_ON2_CELL4 8'h44
`define ECS_CODE_ON2_CURRENT 8'h45
`define ECS_CODE_OFF_CELL1 8'h46
`define ECS_CODE_OFF_CELL2 8'h47
`define ECS_CODE_OFF_CELL3 8'h48
`define ECS_CODE_OFF_CELL4 8'h49
`define ECS_CODE_OFF_CURRENT 8'h4a

// sample slot of the charge current within a set
`define ECS_SLOT_CURRENT 3'h4
// value of every snapshot word after reset
`define ECS_RESET_WORD 16'h0000
// 64 * 182.8uV / 1.955uV: cell lsb over current lsb, in rsns/64 units
`define ECS_ESR_SCALE 13'h1760
// esr answer when the current step is zero or the quotient overflows
`define ECS_ESR_SAT 16'hffff

`endif

/* ecs_esr_calc.sv */
// sequential divider turning the voltage step and current step into esr
`timescale 1ns/1ps
`include "ecs_defines.svh"
module ecs_esr_calc #(
  parameter int NUM_W = 32,
  parameter int DIV_W = 18,
  parameter int RES_W = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [NUM_W-1:0] i_num,
  input wire logic [DIV_W-1:0] i_div,
  output logic [RES_W-1:0] o_result,
  output logic o_done,
  output logic o_busy
);
  import ecs_pkg::*;
  localparam int CNT_W = $clog2(NUM_W + 1);

  logic [NUM_W-1:0] quot_q;
  logic [DIV_W:0] rem_q;
  logic [DIV_W-1:0] div_q;
  logic [NUM_W-1:0] num_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DIV_W:0] rem_sh;
  logic take;
  logic last;
  logic [RES_W-1:0] res_fin;

  // one restoring step per clock, msb first
  assign rem_sh = {rem_q[DIV_W-1:0], quot_q[NUM_W-1]};
  assign take = rem_sh >= {1'b0, div_q};
  assign last = o_busy && (cnt_q == CNT_W'(1));
  // a zero current step or a huge quotient saturates
  assign res_fin = ((div_q == '0) || (quot_q[NUM_W-2:0] >> (RES_W - 1)) != '0) ?
                   `ECS_ESR_SAT : {quot_q[RES_W-2:0], take};

  // restarting on a new start drops any calculation in flight
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      quot_q <= '0;
      rem_q <= '0;
      div_q <= '0;
      num_q <= '0;
      cnt_q <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_result <= '0;
    end else if (i_start) begin
      quot_q <= i_num;
      num_q <= i_num;
      rem_q <= '0;
      div_q <= i_div;
      cnt_q <= CNT_W'(NUM_W);
      o_busy <= 1'b1;
      o_done <= 1'b0;
    end else begin
      o_done <= last;
      if (o_busy) begin
        quot_q <= {quot_q[NUM_W-2:0], take};
        rem_q <= take ? rem_sh - {1'b0, div_q} : rem_sh;
        cnt_q <= cnt_q - CNT_W'(1);
        o_busy <= !last;
      end
      if (last) begin
        o_result <= res_fin; // lsb is rsns/64 [RQ11]
      end
    end
  end

  // quotient stays within one lsb below the true value
  a_esr_quotient_exact: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ11]
    o_done && div_q != '0 && o_result != `ECS_ESR_SAT |->
      (48'(o_result) * 48'(div_q) <= 48'(num_q)) &&
      (48'(num_q) < 48'(o_result + 17'h1) * 48'(div_q)))
    else $error("esr quotient out of range");

  // cycles since the last start, saturating so that it never wraps back onto 32
  logic [5:0] start_age_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      start_age_q <= 6'h3f;
    end else if (i_start) begin
      start_age_q <= 6'h00;
    end else if (start_age_q != 6'h3f) begin
      start_age_q <= start_age_q + 6'h01;
    end
  end

  // a start finishes in exactly the number of numerator bits
  a_esr_calc_time: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ10]
    start_age_q == 6'h20 |-> o_done)
    else $error("esr calculation late");
endmodule : ecs_esr_calc

/* ecs_host_model.sv */
// host-side model issuing register commands to the snapshot bank
`timescale 1ns/1ps
module ecs_host_model
  import ecs_pkg::*;
(
  input wire logic i_clk,
  input wire ecs_pkg::ecs_host_ans_t i_ans,
  output ecs_pkg::ecs_host_req_t o_req
);
  // idle until the first command
  initial begin
    o_req = '0;
  end

  // one command per call, launched at a falling edge; the answer is taken one cycle on
  // released code lines carry the inverse so a stale code never looks live
  task automatic access(input logic is_wr, input logic [7:0] code, output ecs_host_ans_t ans);
    @(negedge i_clk);
    o_req = '{rd: !is_wr, wr: is_wr, code: code};
    @(negedge i_clk);
    ans = i_ans;
    o_req = '{rd: 1'b0, wr: 1'b0, code: ~code};
  endtask : access
endmodule : ecs_host_model

/* ecs_pkg.sv */
// types shared by the snapshot bank and its helpers
package ecs_pkg;

  // which measurement a sample belongs to
  typedef enum logic [2:0] {
    ECS_PH_CAP,
    ECS_PH_BASE,
    ECS_PH_ON1,
    ECS_PH_ON2,
    ECS_PH_OFF
  } ecs_phase_t;

  // one sample from the measurement engine
  typedef struct packed {
    logic valid;
    ecs_phase_t phase;
    logic [2:0] slot;
    logic [15:0] data;
  } ecs_sample_t;

  // one register command from the serial port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] code;
  } ecs_host_req_t;

  // answer to a register command
  typedef struct packed {
    logic valid;
    logic hit;
    logic wr_nak;
    logic [15:0] data;
  } ecs_host_ans_t;

endpackage : ecs_pkg

/* ecs_reg_read.sv */
// command code decode and word select for host reads
`timescale 1ns/1ps
`include "ecs_defines.svh"
module ecs_reg_read #(
  parameter int WORDS = 23,
  parameter int WORD_W = 16
) (
  input wire logic [WORDS-1:0][WORD_W-1:0] i_bank,
  input wire logic [7:0] i_code,
  output logic o_hit,
  output logic [WORD_W-1:0] o_data
);
  import ecs_pkg::*;

  logic [7:0] offs;

  // codes outside the bank answer zero
  assign offs = i_code - `ECS_CODE_CAP_CELL1;
  assign o_hit = (i_code >= `ECS_CODE_CAP_CELL1) && (i_code <= `ECS_CODE_OFF_CURRENT);
  assign o_data = o_hit ? i_bank[offs[4:0]] : '0;
endmodule : ecs_reg_read

/* ecs_snapshot_bank.sv */
// capacitance and esr snapshot word bank with esr computation
`timescale 1ns/1ps
`include "ecs_defines.svh"

// Overview of operation
// RQ1: a capacitance measurement stores the voltage change of cells two to four as 16-bit words.
// RQ2: the cell-one voltage change is stored in the word just below the cell-two word.
// RQ3: before the test current turns on, each cell voltage is kept as a baseline word.
// RQ4: with the test current on, a first sample of each cell voltage is stored.
// RQ5: with that first set, one charge current reading is stored.
// RQ6: still under test current, a second sample of each cell voltage is stored.
// RQ7: with that second set, a second charge current reading is stored.
// RQ8: after the current is off, each cell voltage is sampled once more and stored.
// RQ9: with the current off, a last charge current reading closes the set.
// RQ10: the stack esr is computed from the baseline, current-on and current-off words.
// RQ11: the esr result has one lsb equal to the charge sense resistance over sixty-four.
// RQ12: words keep their value across host reads, and host writes change nothing.
module ecs_snapshot_bank #(
  parameter int WORD_W = 16,
  parameter int NUM_W = 32,
  parameter int DIV_W = 18
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire ecs_pkg::ecs_sample_t i_sample,
  input wire ecs_pkg::ecs_host_req_t i_host,
  output ecs_pkg::ecs_host_ans_t o_host,
  output logic [WORD_W-1:0] o_esr_result,
  output logic o_esr_valid,
  output logic o_esr_busy,
  output logic o_esr_done
);
  import ecs_pkg::*;
  localparam int WORDS = int'(`ECS_CODE_OFF_CURRENT - `ECS_CODE_CAP_CELL1) + 1;
  localparam int STEP_W = WORD_W + 4;

  // command code of a sample's home word
  function automatic logic [7:0] slot_code(ecs_phase_t ph, logic [2:0] slot);
    logic [7:0] first;
    first = `ECS_CODE_CAP_CELL1;
    unique case (ph)
      ECS_PH_CAP: first = `ECS_CODE_CAP_CELL1;
      ECS_PH_BASE: first = `ECS_CODE_BASE_CELL1;
      ECS_PH_ON1: first = `ECS_CODE_ON1_CELL1;
      ECS_PH_ON2: first = `ECS_CODE_ON2_CELL1;
      ECS_PH_OFF: first = `ECS_CODE_OFF_CELL1;
      default: first = `ECS_CODE_CAP_CELL1;
    endcase
    return first + {5'h0, slot};
  endfunction : slot_code

  // a current slot exists only in the three current-bearing sets
  function automatic logic slot_ok(ecs_phase_t ph, logic [2:0] slot);
    logic ok;
    ok = 1'b0;
    unique case (ph)
      ECS_PH_CAP, ECS_PH_BASE: ok = slot < `ECS_SLOT_CURRENT;
      ECS_PH_ON1, ECS_PH_ON2, ECS_PH_OFF: ok = slot <= `ECS_SLOT_CURRENT;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : slot_ok

  // word index of a command code
  function automatic logic [4:0] code_idx(logic [7:0] code);
    logic [7:0] offs;
    offs = code - `ECS_CODE_CAP_CELL1;
    return offs[4:0];
  endfunction : code_idx

  // signed difference of two unsigned words, widened for summing
  function automatic logic signed [STEP_W-1:0] step(logic [WORD_W-1:0] a,
                                                     logic [WORD_W-1:0] b);
    logic signed [STEP_W-1:0] d;
    d = $signed(STEP_W'(a)) - $signed(STEP_W'(b));
    return d;
  endfunction : step

  logic [WORDS-1:0][WORD_W-1:0] bank_q;
  logic wr_en;
  logic [7:0] wr_code;
  logic [4:0] wr_idx;
  logic off_current;
  logic start_q;
  logic rd_hit;
  logic [WORD_W-1:0] rd_data;

  // sample steering into the bank
  assign wr_code = slot_code(i_sample.phase, i_sample.slot);
  assign wr_idx = code_idx(wr_code);
  assign wr_en = i_sample.valid && slot_ok(i_sample.phase, i_sample.slot);
  // the off-set current is always the last word of an esr sequence
  assign off_current = wr_en && i_sample.phase == ECS_PH_OFF &&
                       i_sample.slot == `ECS_SLOT_CURRENT; // [RQ9]

  // snapshot storage; only the engine writes, never the host
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bank_q <= {WORDS{`ECS_RESET_WORD}};
    end else if (wr_en) begin
      bank_q[wr_idx] <= i_sample.data; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ12]
    end
  end

  // host read decode
  ecs_reg_read #(
    .WORDS(WORDS),
    .WORD_W(WORD_W)
  ) u_read (
    .i_bank(bank_q),
    .i_code(i_host.code),
    .o_hit(rd_hit),
    .o_data(rd_data)
  );

  // answer one cycle after the command; writes are refused and flagged
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_host <= '0;
    end else begin
      o_host.valid <= i_host.rd || i_host.wr;
      o_host.hit <= (i_host.rd || i_host.wr) && rd_hit;
      o_host.wr_nak <= i_host.wr; // [RQ12]
      o_host.data <= i_host.rd ? rd_data : '0;
    end
  end

  // turn-on step, turn-off step and current steps for the stack
  logic signed [STEP_W-1:0] v_on;
  logic signed [STEP_W-1:0] v_off;
  logic signed [STEP_W-1:0] v_sum;
  logic signed [STEP_W-1:0] i_sum;
  logic [NUM_W-1:0] esr_num;
  logic [DIV_W-1:0] esr_div;
  logic [NUM_W+12:0] num_full;

  // both edges of the current pulse see the same esr, so summing them
  // halves noise; the drift between the samples cancels to first order
  assign v_on = step(bank_q[code_idx(`ECS_CODE_ON1_CELL1)],
                     bank_q[code_idx(`ECS_CODE_BASE_CELL1)]) +
                step(bank_q[code_idx(`ECS_CODE_ON1_CELL2)],
                     bank_q[code_idx(`ECS_CODE_BASE_CELL2)]) +
                step(bank_q[code_idx(`ECS_CODE_ON1_CELL3)],
                     bank_q[code_idx(`ECS_CODE_BASE_CELL3)]) +
                step(bank_q[code_idx(`ECS_CODE_ON1_CELL4)],
                     bank_q[code_idx(`ECS_CODE_BASE_CELL4)]); // [RQ10]
  assign v_off = step(bank_q[code_idx(`ECS_CODE_ON2_CELL1)],
                      bank_q[code_idx(`ECS_CODE_OFF_CELL1)]) +
                 step(bank_q[code_idx(`ECS_CODE_ON2_CELL2)],
                      bank_q[code_idx(`ECS_CODE_OFF_CELL2)]) +
                 step(bank_q[code_idx(`ECS_CODE_ON2_CELL3)],
                      bank_q[code_idx(`ECS_CODE_OFF_CELL3)]) +
                 step(bank_q[code_idx(`ECS_CODE_ON2_CELL4)],
                      bank_q[code_idx(`ECS_CODE_OFF_CELL4)]); // [RQ10]
  assign v_sum = v_on + v_off;
  assign i_sum = step(bank_q[code_idx(`ECS_CODE_ON1_CURRENT)],
                      bank_q[code_idx(`ECS_CODE_OFF_CURRENT)]) +
                 step(bank_q[code_idx(`ECS_CODE_ON2_CURRENT)],
                      bank_q[code_idx(`ECS_CODE_OFF_CURRENT)]); // [RQ10]
  // negative steps mean a bad measurement; they clamp to zero
  assign num_full = v_sum[STEP_W-1] ? '0 :
                    (NUM_W+13)'(v_sum) * (NUM_W+13)'(`ECS_ESR_SCALE); // [RQ11]
  assign esr_num = (num_full[NUM_W+12:NUM_W] != '0) ? '1 : num_full[NUM_W-1:0];
  assign esr_div = i_sum[STEP_W-1] ? '0 : DIV_W'(i_sum);

  // start one cycle late so the divider sees the final off-current word
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      start_q <= 1'b0;
    end else begin
      start_q <= off_current; // [RQ9] [RQ10]
    end
  end

  logic [WORD_W-1:0] calc_res;
  logic calc_done;
  logic calc_busy;

  ecs_esr_calc #(
    .NUM_W(NUM_W),
    .DIV_W(DIV_W),
    .RES_W(WORD_W)
  ) u_calc (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(start_q),
    .i_num(esr_num),
    .i_div(esr_div),
    .o_result(calc_res),
    .o_done(calc_done),
    .o_busy(calc_busy)
  );

  // result outputs held in their own flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_esr_result <= '0;
      o_esr_valid <= 1'b0;
      o_esr_busy <= 1'b0;
      o_esr_done <= 1'b0;
    end else begin
      o_esr_busy <= calc_busy || start_q;
      o_esr_done <= calc_done;
      if (calc_done) begin
        o_esr_result <= calc_res; // [RQ10] [RQ11]
        o_esr_valid <= 1'b1;
      end
    end
  end

  // cap-set words take the sample of their cell
  a_cap_word_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ1]
    wr_en && i_sample.phase == ECS_PH_CAP && i_sample.slot != 3'h0 |=>
      bank_q[code_idx($past(wr_code))] == $past(i_sample.data))
    else $error("cap delta word not stored");

  a_cap_cell1_word: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ2]
    wr_en && i_sample.phase == ECS_PH_CAP && i_sample.slot == 3'h0 |=>
      bank_q[code_idx(`ECS_CODE_CAP_CELL2) - 5'h1] == $past(i_sample.data))
    else $error("cell one delta not below cell two");

  a_base_word_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ3]
    wr_en && i_sample.phase == ECS_PH_BASE |=>
      bank_q[code_idx(`ECS_CODE_BASE_CELL1) + 5'($past(i_sample.slot))] ==
      $past(i_sample.data))
    else $error("baseline word not stored");

  a_on1_cell_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ4]
    wr_en && i_sample.phase == ECS_PH_ON1 && i_sample.slot < 3'h4 |=>
      bank_q[code_idx(`ECS_CODE_ON1_CELL1) + 5'($past(i_sample.slot))] ==
      $past(i_sample.data))
    else $error("first on-sample not stored");

  a_on1_current_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ5]
    wr_en && i_sample.phase == ECS_PH_ON1 && i_sample.slot == 3'h4 |=>
      bank_q[code_idx(`ECS_CODE_ON1_CURRENT)] == $past(i_sample.data))
    else $error("first current not stored");

  a_on2_cell_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ6]
    wr_en && i_sample.phase == ECS_PH_ON2 && i_sample.slot < 3'h4 |=>
      bank_q[code_idx(`ECS_CODE_ON2_CELL1) + 5'($past(i_sample.slot))] ==
      $past(i_sample.data))
    else $error("second on-sample not stored");

  a_on2_current_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ7]
    wr_en && i_sample.phase == ECS_PH_ON2 && i_sample.slot == 3'h4 |=>
      bank_q[code_idx(`ECS_CODE_ON2_CURRENT)] == $past(i_sample.data))
    else $error("second current not stored");

  a_off_cell_store: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ8]
    wr_en && i_sample.phase == ECS_PH_OFF && i_sample.slot < 3'h4 |=>
      bank_q[code_idx(`ECS_CODE_OFF_CELL1) + 5'($past(i_sample.slot))] ==
      $past(i_sample.data))
    else $error("off sample not stored");

  a_off_current_start: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ9]
    off_current |=> bank_q[code_idx(`ECS_CODE_OFF_CURRENT)] == $past(i_sample.data)
      ##1 o_esr_busy)
    else $error("off current did not start esr");

  // cycles since the divider was started; saturates so a stale count never matches
  logic [5:0] esr_age_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      esr_age_q <= 6'h3f;
    end else if (start_q) begin
      esr_age_q <= 6'h00;
    end else if (esr_age_q != 6'h3f) begin
      esr_age_q <= esr_age_q + 6'h01;
    end
  end

  a_esr_result_due: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ10]
    esr_age_q == 6'h21 |-> o_esr_done && o_esr_valid)
    else $error("esr result missing");

  a_esr_valid_hold: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ10]
    o_esr_valid |=> o_esr_valid)
    else $error("esr valid dropped");

  a_write_refused: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
    i_host.wr && !i_host.rd |=> o_host.valid && o_host.wr_nak &&
      o_host.data == '0)
    else $error("host write not refused");

  a_answer_idle: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
    !i_host.rd && !i_host.wr |=> !o_host.valid && !o_host.wr_nak)
    else $error("answer without a request");

  a_miss_reads_zero: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
    i_host.rd && !rd_hit |=> o_host.valid && !o_host.hit && o_host.data == '0)
    else $error("unmapped read not zero");

  a_host_no_effect: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
    !wr_en |=> bank_q == $past(bank_q))
    else $error("word changed without a sample");

  a_read_answer: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
    i_host.rd && rd_hit |=> o_host.valid && o_host.hit &&
      o_host.data == $past(bank_q[code_idx(i_host.code)]))
    else $error("read answer wrong");
endmodule : ecs_snapshot_bank

/* tb_top.sv */
// self-checking bench for the capacitance/esr snapshot bank
`timescale 1ns/1ps
`include "ecs_defines.svh"
module tb_top;
  import ecs_pkg::*;
  logic i_clk;
  logic i_reset;
  ecs_sample_t sample_bus;
  ecs_host_req_t host_req;
  ecs_host_ans_t host_ans;
  logic [15:0] esr_result;
  logic esr_valid;
  logic esr_busy;
  logic esr_done;
  int mismatches;
  int checked;
  logic [15:0] exp_word [0:22];
  logic [7:0] grp_base [0:4] = '{8'h34, 8'h38, 8'h3c, 8'h41, 8'h46};
  int grp_last [0:4] = '{3, 3, 4, 4, 4};

  ecs_snapshot_bank u_ecs_snapshot_bank (
    .i_clk(i_clk), .i_reset(i_reset), .i_sample(sample_bus), .i_host(host_req),
    .o_host(host_ans), .o_esr_result(esr_result), .o_esr_valid(esr_valid),
    .o_esr_busy(esr_busy), .o_esr_done(esr_done)
  );

  ecs_host_model u_ecs_host_model (.i_clk(i_clk), .i_ans(host_ans), .o_req(host_req));

  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // sample values: currents well above the off reading so the step is positive
  function automatic logic [15:0] sample_val(int p, int s);
    logic [15:0] base;
    base = 16'h03e8 + 16'(10 * s);
    case (p)
      0: sample_val = 16'h0100 + 16'(s);
      1: sample_val = base;
      2: sample_val = (s == 4) ? 16'h012c : base + 16'h0064;
      3: sample_val = (s == 4) ? 16'h0136 : base + 16'h0082;
      default: sample_val = (s == 4) ? 16'h0064 : base - 16'h000a;
    endcase
  endfunction : sample_val

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1

  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // host read with the answer fields checked
  task automatic read_word(input logic [7:0] code, input logic [15:0] exp, input logic hit);
    ecs_host_ans_t ans;
    u_ecs_host_model.access(1'b0, code, ans);
    cmp1(ans.valid, 1'b1);
    cmp1(ans.hit, hit);
    cmp1(ans.wr_nak, 1'b0);
    cmp16(ans.data, exp);
  endtask : read_word

  // one-cycle sample pulse; data lines change afterwards so nothing stale lingers
  task automatic send_sample(input int p, input int s, input logic [15:0] d);
    @(negedge i_clk);
    sample_bus = '{valid: 1'b1, phase: ecs_phase_t'(p), slot: 3'(s), data: d};
    @(negedge i_clk);
    sample_bus.valid = 1'b0;
    sample_bus.data = ~d;
  endtask : send_sample

  // main sequence
  initial begin
    ecs_host_ans_t ans;
    logic seen_busy;
    int n;
    longint dv;
    longint di;
    longint q;
    mismatches = 0;
    checked = 0;
    i_reset = 1'b1;
    sample_bus = '0;
    repeat (10) @(negedge i_clk);
    i_reset = 1'b0;
    // every word is zero out of reset, codes just outside the bank miss
    for (int k = 0; k < 23; k++) begin
      exp_word[k] = 16'h0000;
      read_word(8'(8'h34 + k), 16'h0000, 1'b1);
    end
    read_word(8'h33, 16'h0000, 1'b0);
    read_word(8'h4b, 16'h0000, 1'b0);
    cmp1(esr_valid, 1'b0);
    // fill each legal slot of each phase; the off-current sample comes last and starts esr
    for (int p = 0; p < 5; p++) begin
      for (int s = 0; s <= grp_last[p]; s++) begin
        exp_word[grp_base[p] - 8'h34 + 8'(s)] = sample_val(p, s);
        send_sample(p, s, sample_val(p, s));
      end
    end
    seen_busy = 1'b0;
    n = 0;
    while (esr_done !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      if (esr_busy === 1'b1) begin
        seen_busy = 1'b1;
      end
      n++;
    end
    // a timeout counts as a mismatch; the remaining checks then run down to the report
    if (n >= 100) begin
      mismatches++;
    end
    // expected esr from the stored samples
    dv = 0;
    for (int c = 0; c < 4; c++) begin
      dv += longint'(exp_word[8 + c]) - longint'(exp_word[4 + c]);
      dv += longint'(exp_word[13 + c]) - longint'(exp_word[18 + c]);
    end
    di = longint'(exp_word[12]) + longint'(exp_word[17]) - 2 * longint'(exp_word[22]);
    q = dv * longint'(`ECS_ESR_SCALE) / di;
    if (q >= 64'h0000_0000_0001_0000) begin
      q = 64'h0000_0000_0000_ffff;
    end
    cmp1(seen_busy, 1'b1);
    cmp16(esr_result, 16'(q));
    cmp1(esr_valid, 1'b1);
    @(negedge i_clk);
    cmp1(esr_done, 1'b0);
    cmp1(esr_busy, 1'b0);
    cmp16(esr_result, 16'(q));
    // illegal slots must leave every word alone
    send_sample(0, 4, 16'hdead);
    send_sample(1, 4, 16'hbeef);
    send_sample(2, 5, 16'h5a5a);
    send_sample(4, 7, 16'ha5a5);
    // host writes are refused and flagged
    u_ecs_host_model.access(1'b1, 8'h35, ans);
    cmp1(ans.valid, 1'b1);
    cmp1(ans.wr_nak, 1'b1);
    u_ecs_host_model.access(1'b1, 8'h4a, ans);
    cmp1(ans.wr_nak, 1'b1);
    // read the whole bank twice: values survive writes and earlier reads
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 23; k++) begin
        read_word(8'(8'h34 + k), exp_word[k], 1'b1);
      end
    end
    tally_and_finish();
  end
endmodule : tb_top
